// [hdl/variance_monitor_pkg.sv]
// Purpose: Constants for the receive variance monitor register bank
// Assumes: One 25 MHz clock; register port addresses are five bits wide
// Notes:   Timing counts derive from the unit time and the clock period
//
// What this block does
// R01: Period code 0..3 selects 2/4/6/8 ms
// R02: One ms unit is 2^17 8ns cycles
// R03: Control bit 0 enables computation, reset off
// R04: Keep 32-bit sum, read via 16-bit register
// R05: Software trusts data only while ready set
// R06: Software freezes on ready to keep result
// R07: After freeze, first read low, second high
// R08: Software reads data register twice per sum
// R09: Ready sets on load, clears after pair
// R10: Freeze holds data, clears after read pair
// R11: Writing new period code restarts computation
// R12: Load result each period unless frozen
// R13: Setting freeze resets the half pointer
package variance_monitor_pkg;

    // Register addresses
    localparam logic [4:0]  CTRL_ADDR       = 5'h1a;
    localparam logic [4:0]  RESULT_ADDR     = 5'h1b;
    localparam logic [4:0]  IRQ_STATUS_ADDR = 5'h10;
    localparam logic [4:0]  IRQ_MASK_ADDR   = 5'h11;

    // Control register fields
    localparam int          ENABLE_BIT      = 0;
    localparam int          SEL_LSB         = 1;
    localparam int          FREEZE_BIT      = 3;
    localparam int          READY_BIT       = 15;

    // Interrupt status and mask fields
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_LOADED_BIT  = 0;
    localparam int          IRQ_DROPPED_BIT = 1;

    // Reset values
    localparam logic [1:0]  SEL_RESET       = 2'h0;
    localparam logic [31:0] RESULT_RESET    = 32'h0;
    localparam logic [15:0] RDATA_IDLE      = 16'h0;

    // Timing
    localparam int          MCLK_NS         = 40;
    localparam int          INT_CLK_NS      = 8;
    localparam int          UNIT_EXP        = 17;
    localparam int          UNIT_NS         = INT_CLK_NS * (2 ** UNIT_EXP);
    localparam int          UNIT_CYCLES_DEF = UNIT_NS / MCLK_NS;
    localparam int          SUB_W           = 16;
    localparam int          UNIT_W          = 4;
    localparam int          CYC_W           = 20;

endpackage

// [hdl/variance_period_timer.sv]
// Purpose: Variance computation period timer with one-cycle elapse pulse
// Assumes: Restart and enable are synchronous to mclk
// Notes:   Period is UNIT_CYCLES times twice (code + 1)
`timescale 1ns/10ps
module variance_period_timer
    import variance_monitor_pkg::*;
#(
    parameter int UNIT_CYCLES = UNIT_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Control
    input  wire logic       enable,
    input  wire logic       restart,
    input  wire logic [1:0] sel,
    // Event
    output logic            elapsed
);

    logic [SUB_W-1:0]  sub_reg;
    logic [UNIT_W-1:0] unit_reg;
    logic [UNIT_W-1:0] last_unit;
    logic              sub_end;
    logic              period_end;
    logic              hold;
    logic [CYC_W-1:0]  cyc_reg;

    // Last unit index is 2*code + 1
    assign last_unit  = {1'b0, sel, 1'b1}; // R01
    assign sub_end    = sub_reg == SUB_W'(UNIT_CYCLES - 1); // R02
    assign hold       = !enable || restart;
    assign period_end = !hold && sub_end && unit_reg == last_unit;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sub_reg  <= '0;
            unit_reg <= '0;
        end else if (hold) begin
            sub_reg  <= '0;
            unit_reg <= '0;
        end else if (sub_end) begin
            sub_reg  <= '0;
            unit_reg <= (unit_reg == last_unit) ? '0 : unit_reg + 1'b1;
        end else begin
            sub_reg  <= sub_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            elapsed <= 1'b0;
        end else begin
            elapsed <= period_end;
        end
    end

    // Checking aid: cycles since the period began
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cyc_reg <= '0;
        end else if (hold || period_end) begin
            cyc_reg <= '0;
        end else begin
            cyc_reg <= cyc_reg + 1'b1;
        end
    end

    a_period_length: assert property ( // R01
        @(posedge mclk) disable iff (rst)
        period_end |-> cyc_reg == CYC_W'(UNIT_CYCLES * (2 * sel + 2) - 1))
        else $error("period length wrong for code");

    a_off_quiet: assert property ( // R03
        @(posedge mclk) disable iff (rst)
        !enable |=> !elapsed)
        else $error("timer elapsed while disabled");

endmodule

// [hdl/variance_monitor_regs.sv]
// Purpose: Control and readout registers of the receive variance monitor
// Assumes: Samples arrive from the datapath on var_sample_valid
// Notes:   Result is read as two halves, low first, under freeze
`timescale 1ns/10ps
module variance_monitor_regs
    import variance_monitor_pkg::*;
#(
    parameter int UNIT_CYCLES = UNIT_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Variance samples from the datapath
    input  wire logic        var_sample_valid,
    input  wire logic [15:0] var_sample,
    // Interrupt
    output logic             irq
);

    logic             enable_reg;
    logic [1:0]       sel_reg;
    logic             freeze_reg;
    logic             ready_reg;
    logic             half_reg;
    logic [31:0]      acc_reg;
    logic [31:0]      result_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;

    logic             ctrl_wr;
    logic             data_rd;
    logic             status_wr;
    logic             mask_wr;
    logic [1:0]       sel_next;
    logic             restart;
    logic             elapsed;
    logic             load;
    logic             drop;
    logic             pair_done;
    logic             freeze_set;
    logic [15:0]      result_low;
    logic [15:0]      result_high;
    logic [15:0]      ctrl_view;
    logic [IRQ_W-1:0] irq_set;

    assign ctrl_wr    = reg_wr && reg_addr == CTRL_ADDR;
    assign data_rd    = reg_rd && reg_addr == RESULT_ADDR;
    assign status_wr  = reg_wr && reg_addr == IRQ_STATUS_ADDR;
    assign mask_wr    = reg_wr && reg_addr == IRQ_MASK_ADDR;
    assign sel_next   = reg_wdata[SEL_LSB +: 2];

    // Only a changed code restarts; rewriting the same code keeps the period
    assign restart    = ctrl_wr && sel_next != sel_reg; // R11

    // Frozen result is never overwritten; the new sum is dropped instead
    assign load       = elapsed && enable_reg && !freeze_reg; // R12
    assign drop       = elapsed && enable_reg && freeze_reg;

    // Second read of the pair
    assign pair_done  = data_rd && half_reg;
    assign freeze_set = ctrl_wr && reg_wdata[FREEZE_BIT] && !freeze_reg;

    assign result_low  = result_reg[15:0];
    assign result_high = result_reg[31:16];

    always_comb begin
        ctrl_view             = '0;
        ctrl_view[ENABLE_BIT] = enable_reg;
        ctrl_view[SEL_LSB +: 2] = sel_reg;
        ctrl_view[FREEZE_BIT] = freeze_reg;
        ctrl_view[READY_BIT]  = ready_reg;
    end

    variance_period_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) period_timer (
        .mclk    (mclk),
        .rst     (rst),
        .enable  (enable_reg),
        .restart (restart),
        .sel     (sel_reg),
        .elapsed (elapsed)
    );

    // Enable and period code
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable_reg <= 1'b0; // R03
            sel_reg    <= SEL_RESET;
        end else if (ctrl_wr) begin
            enable_reg <= reg_wdata[ENABLE_BIT]; // R03
            sel_reg    <= sel_next; // R01
        end
    end

    // Freeze: software sets, a completed read pair clears
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            freeze_reg <= 1'b0;
        end else if (ctrl_wr) begin
            freeze_reg <= reg_wdata[FREEZE_BIT];
        end else if (pair_done) begin
            freeze_reg <= 1'b0; // R10
        end
    end

    // Ready: a load in the same cycle as the pair end wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ready_reg <= 1'b0;
        end else if (load) begin
            ready_reg <= 1'b1; // R09
        end else if (pair_done) begin
            ready_reg <= 1'b0; // R09
        end
    end

    // Half pointer; reads of other registers do not break the pair
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            half_reg <= 1'b0;
        end else if (freeze_set) begin
            half_reg <= 1'b0; // R13
        end else if (data_rd) begin
            half_reg <= ~half_reg; // R07
        end
    end

    // Accumulator; wraps at 32 bits, the datapath sizes samples to fit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_reg <= RESULT_RESET;
        end else if (!enable_reg || restart) begin
            acc_reg <= RESULT_RESET; // R11
        end else if (elapsed) begin
            acc_reg <= var_sample_valid ? {16'h0, var_sample} : RESULT_RESET;
        end else if (var_sample_valid) begin
            acc_reg <= acc_reg + {16'h0, var_sample};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_reg <= RESULT_RESET; // R04
        end else if (load) begin
            result_reg <= acc_reg; // R12
        end
    end

    // Read data stand one cycle after the strobe only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RDATA_IDLE;
        end else if (reg_rd) begin
            case (reg_addr)
                CTRL_ADDR:       reg_rdata <= ctrl_view;
                RESULT_ADDR:     reg_rdata <= half_reg ? result_high : result_low; // R07
                IRQ_STATUS_ADDR: reg_rdata <= {{(16-IRQ_W){1'b0}}, irq_status_reg};
                IRQ_MASK_ADDR:   reg_rdata <= {{(16-IRQ_W){1'b0}}, irq_mask_reg};
                default:         reg_rdata <= RDATA_IDLE;
            endcase
        end else begin
            reg_rdata <= RDATA_IDLE;
        end
    end

    // Interrupt status: set beats write-one-to-clear
    always_comb begin
        irq_set                  = '0;
        irq_set[IRQ_LOADED_BIT]  = load;
        irq_set[IRQ_DROPPED_BIT] = drop;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg
                               & ~(status_wr ? reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                              | irq_set;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= '0;
        end else if (mask_wr) begin
            irq_mask_reg <= reg_wdata[IRQ_W-1:0];
        end
    end

    // Registered, so the line follows status by one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    a_ready_on_load: assert property ( // R09
        @(posedge mclk) disable iff (rst)
        load |=> ready_reg && result_reg == $past(acc_reg))
        else $error("ready or result not set on load");

    a_pair_ready: assert property ( // R09
        @(posedge mclk) disable iff (rst)
        pair_done && !load |=> !ready_reg)
        else $error("ready survived a read pair");

    a_pair_freeze: assert property ( // R10
        @(posedge mclk) disable iff (rst)
        pair_done |=> !freeze_reg)
        else $error("freeze survived a read pair");

    a_frozen_held: assert property ( // R12
        @(posedge mclk) disable iff (rst)
        freeze_reg && !ctrl_wr |=> $stable(result_reg))
        else $error("frozen result changed");

    a_low_first: assert property ( // R07
        @(posedge mclk) disable iff (rst)
        data_rd && !half_reg |=> reg_rdata == $past(result_low))
        else $error("first read of a pair not low half");

    a_high_second: assert property ( // R07
        @(posedge mclk) disable iff (rst)
        data_rd && half_reg |=> reg_rdata == $past(result_high))
        else $error("second read not high half");

    a_freeze_ptr: assert property ( // R13
        @(posedge mclk) disable iff (rst)
        freeze_set |=> !half_reg && freeze_reg)
        else $error("freeze did not reset half pointer");

    a_code_restart: assert property ( // R11
        @(posedge mclk) disable iff (rst)
        restart |=> !elapsed[*2] ##0 acc_reg == RESULT_RESET)
        else $error("period code change did not restart");

    a_off_clears: assert property ( // R03
        @(posedge mclk) disable iff (rst)
        !enable_reg |=> acc_reg == RESULT_RESET && !load)
        else $error("accumulating while disabled");

    a_irq_follows: assert property (
        @(posedge mclk) disable iff (rst)
        |(irq_status_reg & irq_mask_reg) |=> irq)
        else $error("interrupt not raised");

    a_irq_clears: assert property (
        @(posedge mclk) disable iff (rst)
        !(|(irq_status_reg & irq_mask_reg)) |=> !irq)
        else $error("interrupt raised with nothing pending");

    a_rdata_idle: assert property (
        @(posedge mclk) disable iff (rst)
        !reg_rd |=> reg_rdata == RDATA_IDLE)
        else $error("read data not idle without a read");

    a_load_status: assert property ( // R12
        @(posedge mclk) disable iff (rst)
        load |=> irq_status_reg[IRQ_LOADED_BIT])
        else $error("loaded status not set");

    a_drop_status: assert property ( // R12
        @(posedge mclk) disable iff (rst)
        drop |=> irq_status_reg[IRQ_DROPPED_BIT] && $stable(result_reg))
        else $error("dropped result not flagged or result overwritten");

    a_ctrl_readback: assert property ( // R09
        @(posedge mclk) disable iff (rst)
        reg_rd && reg_addr == CTRL_ADDR
        |=> reg_rdata[READY_BIT] == $past(ready_reg) && reg_rdata[FREEZE_BIT] == $past(freeze_reg))
        else $error("control read back wrong");

    a_ready_hold: assert property ( // R09
        @(posedge mclk) disable iff (rst)
        ready_reg && !pair_done |=> ready_reg)
        else $error("ready dropped before a read pair");

    a_enable_write: assert property ( // R03
        @(posedge mclk) disable iff (rst)
        ctrl_wr |=> enable_reg == $past(reg_wdata[ENABLE_BIT]))
        else $error("enable bit not written");

    a_sel_write: assert property ( // R01
        @(posedge mclk) disable iff (rst)
        ctrl_wr |=> sel_reg == $past(sel_next))
        else $error("period code not written");

    a_half_toggle: assert property ( // R07
        @(posedge mclk) disable iff (rst)
        data_rd && !freeze_set |=> half_reg != $past(half_reg))
        else $error("half pointer did not advance");

    c_load: cover property (@(posedge mclk) disable iff (rst) load);
    c_drop: cover property (@(posedge mclk) disable iff (rst) drop);
    c_pair: cover property (@(posedge mclk) disable iff (rst) freeze_set ##[1:20] pair_done);
    c_restart: cover property (@(posedge mclk) disable iff (rst) restart);
    c_irq: cover property (@(posedge mclk) disable iff (rst) $rose(irq));

endmodule

// [sim/variance_monitor_regs_bench.sv]
// Purpose: Self-checking bench for the variance monitor register bank
// Assumes: Short time unit of 8 clocks; samples come only from the bench
// Notes:   Period checks allow a few cycles of load and interrupt lag
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module variance_monitor_regs_bench;
    import variance_monitor_pkg::*;
    localparam int UNIT = 8;
    logic        mclk;
    logic        rst;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        var_sample_valid;
    logic [15:0] var_sample;
    logic        irq;
    int          miscompares;
    int          n_tests;
    logic [15:0] d;

    variance_monitor_regs #(.UNIT_CYCLES(UNIT)) DUT (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .var_sample_valid(var_sample_valid), .var_sample(var_sample), .irq(irq));

    always #20 mclk = ~mclk;

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Counts clocks until irq rises; a hang ends the run
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge mclk);
            #1 n++;
            if (n > 300) begin
                miscompares++;
                tally_and_finish();
            end
        end
    endtask

    task automatic test_reset();
        reg_read(CTRL_ADDR, d);       `CHK(d, 16'h0000)
        reg_read(RESULT_ADDR, d);     `CHK(d, 16'h0000)
        reg_read(IRQ_STATUS_ADDR, d); `CHK(d, 16'h0000)
        reg_read(IRQ_MASK_ADDR, d);   `CHK(d, 16'h0000)
        `CHK(irq, 1'b0)
        reg_write(5'h05, 16'hffff);
        reg_read(5'h05, d);           `CHK(d, 16'h0000)
        // Reserved bits ignored, enable and freeze left clear
        reg_write(CTRL_ADDR, 16'hfff0);
        reg_read(CTRL_ADDR, d);       `CHK(d, 16'h0000)
    endtask

    task automatic test_load_pair();
        int k;
        reg_write(CTRL_ADDR, 16'h0001);
        repeat (3) begin
            @(posedge mclk);
            var_sample_valid <= 1'b1;
            var_sample       <= 16'hffff;
        end
        @(posedge mclk);
        var_sample_valid <= 1'b0;
        // Poll ready; the next period is long enough to freeze in time
        d = 16'h0;
        for (k = 0; k < 40 && d[READY_BIT] !== 1'b1; k++) reg_read(CTRL_ADDR, d);
        if (d[READY_BIT] !== 1'b1) begin miscompares++; tally_and_finish(); end
        `CHK(d, 16'h8001)
        reg_write(CTRL_ADDR, 16'h0009);
        repeat (40) @(posedge mclk);
        reg_read(IRQ_STATUS_ADDR, d); `CHK(d, 16'h0003)
        reg_write(CTRL_ADDR, 16'h0008);
        reg_read(RESULT_ADDR, d);     `CHK(d, 16'hfffd)
        reg_read(CTRL_ADDR, d);       `CHK(d, 16'h8008)
        reg_read(RESULT_ADDR, d);     `CHK(d, 16'h0002)
        reg_read(CTRL_ADDR, d);       `CHK(d, 16'h0000)
        // Masked status must not reach the pin
        `CHK(irq, 1'b0)
        reg_write(IRQ_MASK_ADDR, 16'h0001);
        repeat (2) @(posedge mclk);
        #1 `CHK(irq, 1'b1)
        reg_write(IRQ_STATUS_ADDR, 16'h0003);
        repeat (2) @(posedge mclk);
        #1 `CHK(irq, 1'b0)
    endtask

    task automatic test_pointer_reset();
        reg_read(RESULT_ADDR, d);     `CHK(d, 16'hfffd)
        reg_write(CTRL_ADDR, 16'h0008);
        reg_read(RESULT_ADDR, d);     `CHK(d, 16'hfffd)
        reg_read(RESULT_ADDR, d);     `CHK(d, 16'h0002)
    endtask

    task automatic test_periods();
        int n;
        int p;
        for (int code = 0; code < 4; code++) begin
            reg_write(CTRL_ADDR, 16'h0000);
            reg_write(IRQ_STATUS_ADDR, 16'h0003);
            reg_write(CTRL_ADDR, 16'(code * 2 + 1));
            p = UNIT * (2 * code + 2);
            wait_irq(n);
            `CHK(n >= p && n <= p + 4, 1'b1)
        end
        // A changed code restarts the timer from the write
        reg_write(CTRL_ADDR, 16'h0000);
        reg_write(IRQ_STATUS_ADDR, 16'h0003);
        reg_write(CTRL_ADDR, 16'h0003);
        repeat (20) @(posedge mclk);
        reg_write(CTRL_ADDR, 16'h0001);
        wait_irq(n);
        `CHK(n >= 2 * UNIT && n <= 2 * UNIT + 4, 1'b1)
        reg_write(CTRL_ADDR, 16'h0000);
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        var_sample_valid = 1'b0;
        var_sample = 16'h0000;
        miscompares = 0;
        n_tests = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        test_reset();
        test_load_pair();
        test_pointer_reset();
        test_periods();
        tally_and_finish();
    end

    // Overall limit against a stuck scenario
    initial begin
        #4000000;
        miscompares++;
        tally_and_finish();
    end
endmodule
